//--- design/pbc_pkg.sv
`default_nettype none
package pbc_pkg;
   // -----------------------------
   // Register map
   // -----------------------------
   localparam logic [4:0] PBC_ADDR_BASIC_MODE_CONTROL = 5'h00;
   localparam logic [15:0] PBC_RESET_VALUE = 16'h3100;
   localparam int PBC_BIT_RESET = 15;
   localparam int PBC_BIT_LOOPBACK = 14;
   localparam int PBC_BIT_SPEED = 13;
   localparam int PBC_BIT_AN_ENABLE = 12;
   localparam int PBC_BIT_POWER_DOWN = 11;
   localparam int PBC_BIT_ISOLATE = 10;
   localparam int PBC_BIT_AN_RESTART = 9;
   localparam int PBC_BIT_DUPLEX = 8;
   localparam int PBC_BIT_COLL_TEST = 7;
   localparam int PBC_RSVD_W = 7;

   // -----------------------------
   // Timing
   // -----------------------------
   localparam int PBC_CLOCK_HZ = 20000000;
   localparam int PBC_DEAD_TIME_MS = 720;
   localparam int PBC_DEAD_CYCLES = PBC_DEAD_TIME_MS * (PBC_CLOCK_HZ / 1000);
   localparam int PBC_DEAD_W = 24;
   localparam int PBC_SRESET_W = 4;
   localparam logic [PBC_SRESET_W-1:0] PBC_SRESET_LAST = 4'hF;

   // -----------------------------
   // Control sequencer
   // -----------------------------
   typedef enum logic [1:0] {
      PBC_ST_RUN = 2'b01,
      PBC_ST_SRESET = 2'b10
   } pbc_state_e;
endpackage
`default_nettype wire

//--- design/pbc_dead_timer.sv
`timescale 1ns/10ps
`default_nettype none
module pbc_dead_timer
   import pbc_pkg::*;
#(
   parameter int CYCLES = PBC_DEAD_CYCLES
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Control
   input wire logic i_start,
   output logic o_busy
);
   logic [PBC_DEAD_W-1:0] count;

   // -----------------------------
   // Countdown
   // -----------------------------
   // dead time count
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         count <= '0;
      end else if (i_start) begin
         count <= PBC_DEAD_W'(CYCLES);
      end else if (count != '0) begin
         count <= count - PBC_DEAD_W'(1);
      end
   end

   assign o_busy = (count != '0);

   AST_DEAD_COUNTS_DOWN: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (count > PBC_DEAD_W'(1) && !i_start) |=> (count == $past(count) - PBC_DEAD_W'(1)))
      else $error("dead timer did not count down");
endmodule // pbc_dead_timer
`default_nettype wire

//--- design/pbc_control.sv
// Operation
// - Writing one to bit 15 returns every field to default; the bit reads one until the sequence ends.
// - Setting loopback blanks receive valid for the 720 ms descrambler dead time.
// - With auto-negotiation enabled, speed and duplex read the negotiated result.
// - Power-down keeps management alive and drives only collision, held low, on the converter link.
// - While isolated, transmit data and transmit enable are ignored.
// - While isolated, transmit clock, receive valid and receive data are released.
// - While isolated, management reads and writes complete normally.
// - Writing one to bit 9 restarts negotiation; it reads one until the restart is issued.
// - Writing zero to restart does not disturb a negotiation already under way.
// - The duplex bit selects full duplex only with auto-negotiation disabled.
// - With auto-negotiation enabled, the duplex bit reads the negotiated duplex.
// - With collision test set, collision follows transmit enable.
// - Bits 6 to 0 are reserved, written as zero and read as zero.
// - Power-down by bit or pin stops all link functions except management.
`timescale 1ns/10ps
`default_nettype none
module pbc_control
   import pbc_pkg::*;
#(
   parameter int DEAD_CYCLES = PBC_DEAD_CYCLES
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Management register access
   input wire logic i_mgmt_wr_en,
   input wire logic i_mgmt_rd_en,
   input wire logic [4:0] i_mgmt_addr,
   input wire logic [15:0] i_mgmt_wdata,
   output logic [15:0] o_mgmt_rdata,
   output logic o_mgmt_rdata_valid,
   // Auto-negotiation engine
   input wire logic i_an_speed_100,
   input wire logic i_an_full_duplex,
   output logic o_an_restart,
   output logic o_full_duplex,
   // Power
   input wire logic i_power_down_pin,
   output logic o_power_down,
   // Datapath core side
   input wire logic i_core_tx_clock,
   input wire logic i_core_rx_valid,
   input wire logic [1:0] i_core_rxd,
   input wire logic i_core_collision,
   output logic o_core_tx_enable,
   output logic [1:0] o_core_txd,
   // Converter link
   input wire logic i_link_transmit_enable,
   input wire logic [1:0] i_link_txd,
   output logic o_link_transmit_clock,
   output logic o_link_transmit_clock_oe,
   output logic o_link_receive_valid,
   output logic o_link_receive_valid_oe,
   output logic [1:0] o_link_rxd,
   output logic o_link_rxd_oe,
   output logic o_link_collision
);
   pbc_state_e state;
   logic [PBC_SRESET_W-1:0] sreset_cnt;
   logic loopback, speed, an_enable, power_down, isolate, an_restart, duplex, coll_test;
   logic write_hit, pd_eff, link_off, tx_en_eff, dead_busy, rx_src_valid;
   logic [1:0] rx_src_data;
   logic [15:0] read_word, field_word;

   function automatic logic [15:0] pack_word(input logic rst, input logic lb, input logic spd, input logic an,
                                             input logic pd, input logic iso, input logic rs, input logic dup,
                                             input logic col);
      pack_word = {rst, lb, spd, an, pd, iso, rs, dup, col, PBC_RSVD_W'(0)};
   endfunction

   // -----------------------------
   // Soft reset sequencer
   // -----------------------------
   // Writes are not taken while the soft reset runs
   assign write_hit = i_mgmt_wr_en && (i_mgmt_addr == PBC_ADDR_BASIC_MODE_CONTROL) && (state == PBC_ST_RUN);

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         state <= PBC_ST_RUN;
         sreset_cnt <= '0;
      end else begin
         case (state)
            PBC_ST_RUN: begin
               if (write_hit && i_mgmt_wdata[PBC_BIT_RESET]) begin
                  state <= PBC_ST_SRESET;
                  sreset_cnt <= PBC_SRESET_LAST;
               end
            end
            PBC_ST_SRESET: begin
               if (sreset_cnt == '0) begin
                  state <= PBC_ST_RUN;
               end else begin
                  sreset_cnt <= sreset_cnt - PBC_SRESET_W'(1);
               end
            end
            default: begin
               state <= PBC_ST_RUN;
            end
         endcase
      end
   end

   // -----------------------------
   // Control fields
   // -----------------------------
   // defaults on either reset
   always_ff @(posedge i_clock) begin
      if (!i_rst_n || state == PBC_ST_SRESET) begin
         loopback <= PBC_RESET_VALUE[PBC_BIT_LOOPBACK];
         speed <= PBC_RESET_VALUE[PBC_BIT_SPEED];
         an_enable <= PBC_RESET_VALUE[PBC_BIT_AN_ENABLE];
         power_down <= PBC_RESET_VALUE[PBC_BIT_POWER_DOWN];
         isolate <= PBC_RESET_VALUE[PBC_BIT_ISOLATE];
         duplex <= PBC_RESET_VALUE[PBC_BIT_DUPLEX];
         coll_test <= PBC_RESET_VALUE[PBC_BIT_COLL_TEST];
      end else if (write_hit) begin
         loopback <= i_mgmt_wdata[PBC_BIT_LOOPBACK];
         speed <= i_mgmt_wdata[PBC_BIT_SPEED];
         an_enable <= i_mgmt_wdata[PBC_BIT_AN_ENABLE];
         power_down <= i_mgmt_wdata[PBC_BIT_POWER_DOWN];
         isolate <= i_mgmt_wdata[PBC_BIT_ISOLATE];
         duplex <= i_mgmt_wdata[PBC_BIT_DUPLEX];
         coll_test <= i_mgmt_wdata[PBC_BIT_COLL_TEST];
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n || state == PBC_ST_SRESET) begin
         an_restart <= 1'b0;
         o_an_restart <= 1'b0;
      end else begin
         o_an_restart <= an_restart && an_enable;
         if (write_hit && i_mgmt_wdata[PBC_BIT_AN_RESTART]) begin
            an_restart <= 1'b1;
         end else begin
            an_restart <= 1'b0;
         end
      end
   end

   // -----------------------------
   // Management read
   // -----------------------------
   assign field_word = pack_word(1'b0, loopback, speed, an_enable, power_down, isolate, 1'b0, duplex, coll_test);
   assign read_word = pack_word(state == PBC_ST_SRESET, loopback, an_enable ? i_an_speed_100 : speed, an_enable,
                                power_down, isolate, an_restart, an_enable ? i_an_full_duplex : duplex, coll_test);

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_mgmt_rdata <= '0;
         o_mgmt_rdata_valid <= 1'b0;
      end else begin
         o_mgmt_rdata_valid <= i_mgmt_rd_en;
         if (i_mgmt_rd_en) begin
            o_mgmt_rdata <= (i_mgmt_addr == PBC_ADDR_BASIC_MODE_CONTROL) ? read_word : 16'h0000;
         end
      end
   end

   // -----------------------------
   // Converter link
   // -----------------------------
   // bit or pin powers down
   assign pd_eff = power_down || i_power_down_pin;
   assign link_off = pd_eff || isolate;
   assign tx_en_eff = i_link_transmit_enable && !link_off;
   assign rx_src_valid = loopback ? tx_en_eff : i_core_rx_valid;
   assign rx_src_data = loopback ? i_link_txd : i_core_rxd;

   pbc_dead_timer #(
      .CYCLES(DEAD_CYCLES)
   ) u_dead_timer (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_start(write_hit && i_mgmt_wdata[PBC_BIT_LOOPBACK] && !loopback),
      .o_busy(dead_busy)
   );

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_core_tx_enable <= 1'b0;
         o_core_txd <= 2'b00;
         o_link_transmit_clock <= 1'b0;
         o_link_receive_valid <= 1'b0;
         o_link_rxd <= 2'b00;
         o_link_transmit_clock_oe <= 1'b0;
         o_link_receive_valid_oe <= 1'b0;
         o_link_rxd_oe <= 1'b0;
         o_link_collision <= 1'b0;
         o_full_duplex <= PBC_RESET_VALUE[PBC_BIT_DUPLEX];
         o_power_down <= 1'b0;
      end else begin
         o_core_tx_enable <= tx_en_eff && !loopback;
         o_core_txd <= link_off ? 2'b00 : i_link_txd;
         o_link_transmit_clock <= i_core_tx_clock && !link_off;
         o_link_receive_valid <= rx_src_valid && !dead_busy && !link_off;
         o_link_rxd <= link_off ? 2'b00 : rx_src_data;
         o_link_transmit_clock_oe <= !link_off;
         o_link_receive_valid_oe <= !link_off;
         o_link_rxd_oe <= !link_off;
         o_link_collision <= !link_off && ((coll_test && tx_en_eff) || i_core_collision);
         o_full_duplex <= an_enable ? i_an_full_duplex : duplex;
         o_power_down <= pd_eff;
      end
   end

   // -----------------------------
   // Checks
   // -----------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   sequence s_sreset_write;
      write_hit && i_mgmt_wdata[PBC_BIT_RESET];
   endsequence
   sequence s_sreset_busy;
      (state == PBC_ST_SRESET && read_word[PBC_BIT_RESET])[*8];
   endsequence
   sequence s_restart_req;
      an_restart && an_enable;
   endsequence
   sequence s_restart_done;
      o_an_restart && !an_restart;
   endsequence

   AST_SRESET_HOLDS_ONE: assert property (s_sreset_write |=> s_sreset_busy)
      else $error("reset bit not held during soft reset");
   AST_SRESET_DEFAULTS: assert property ((state == PBC_ST_SRESET && sreset_cnt == '0)
      |=> (field_word == PBC_RESET_VALUE && state == PBC_ST_RUN && !read_word[PBC_BIT_RESET]))
      else $error("soft reset did not restore defaults");
   AST_RESET_VALUE: assert property ($rose(i_rst_n) |-> (field_word == PBC_RESET_VALUE))
      else $error("wrong reset value");
   AST_DEAD_BLANK: assert property (dead_busy |=> !o_link_receive_valid)
      else $error("receive valid during dead time");
   AST_AN_DUPLEX: assert property ((i_mgmt_rd_en && an_enable && i_mgmt_addr == PBC_ADDR_BASIC_MODE_CONTROL)
      |=> (o_mgmt_rdata[PBC_BIT_DUPLEX] == $past(i_an_full_duplex)))
      else $error("duplex bit not negotiated value");
   AST_PD_QUIET: assert property (pd_eff
      |=> (!o_link_receive_valid_oe && !o_link_collision && !o_core_tx_enable))
      else $error("link active in power down");
   AST_ISO_RELEASE: assert property (isolate
      |=> (!o_link_transmit_clock_oe && !o_link_rxd_oe && !o_core_tx_enable))
      else $error("link driven while isolated");
   AST_ISO_MGMT: assert property ((isolate && i_mgmt_rd_en) |=> o_mgmt_rdata_valid)
      else $error("read not answered while isolated");
   AST_RESTART_ISSUED: assert property ((s_restart_req and (!write_hit)) |=> s_restart_done)
      else $error("restart not issued");
   AST_COLL_TEST: assert property ((coll_test && i_link_transmit_enable && !link_off) |=> o_link_collision)
      else $error("collision test failed");
   AST_RSVD_ZERO: assert property (i_mgmt_rd_en |=> (o_mgmt_rdata[6:0] == 7'h00))
      else $error("reserved bits nonzero");
endmodule // pbc_control
`default_nettype wire

//--- tb/pbc_mgmt_model.sv
`timescale 1ns/10ps
`default_nettype none
module pbc_mgmt_model (
   // Clock
   input wire logic i_clock,
   // Register port
   input wire logic [15:0] i_rdata,
   input wire logic i_rdata_valid,
   output logic o_wr_en,
   output logic o_rd_en,
   output logic [4:0] o_addr,
   output logic [15:0] o_wdata
);
   initial begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr = 5'h0;
      o_wdata = 16'h0;
   end
   function automatic logic [15:0] san(input logic [15:0] d);
      return {d[15:14], 1'b1, d[12:10], d[9] & d[12], d[8:7], 7'h0};
   endfunction
   // Optional second word keeps the strobe high for a back-to-back write
   task automatic wr(input logic [15:0] d, input logic [15:0] d2 = 16'h0, input bit two = 1'b0);
      @(posedge i_clock);
      o_wr_en <= 1'b1;
      o_addr <= 5'h0;
      o_wdata <= san(d);
      if (two) begin
         @(posedge i_clock);
         o_wdata <= san(d2);
      end
      @(posedge i_clock);
      o_wr_en <= 1'b0;
   endtask
   task automatic rd(output logic [15:0] d);
      @(posedge i_clock);
      o_rd_en <= 1'b1;
      o_addr <= 5'h0;
      @(posedge i_clock);
      o_rd_en <= 1'b0;
      @(negedge i_clock);
      d = i_rdata_valid ? i_rdata : 16'hXXXX;
   endtask
endmodule // pbc_mgmt_model
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import pbc_pkg::*;
   localparam int DEAD = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic an_spd = 1'b1;
   logic an_fd = 1'b1;
   logic pd_pin = 1'b0;
   logic c_rxv = 1'b1;
   logic l_link_transmit_enable = 1'b0;
   logic c_tclk = 1'b1;
   logic c_col = 1'b0;
   logic [1:0] c_rxd = 2'h2;
   logic [1:0] l_txd = 2'h1;
   logic wr_en, rd_en, rdv, restart, fdx, pd, ctxen, tclk, tclk_oe, rxv, rxv_oe, rxd_oe, col;
   logic [4:0] addr;
   logic [15:0] wdata, rdata, d;
   logic [1:0] ctxd, rxd;
   int num_errors = 0;
   int total_checks = 0;
   int pulses = 0;
   always #25 clk = ~clk;
   always @(posedge clk) pulses <= pulses + int'(restart);
   pbc_control #(.DEAD_CYCLES(DEAD)) i_pbc_control (
      .i_clock(clk), .i_rst_n(rst_n), .i_mgmt_wr_en(wr_en), .i_mgmt_rd_en(rd_en),
      .i_mgmt_addr(addr), .i_mgmt_wdata(wdata), .o_mgmt_rdata(rdata), .o_mgmt_rdata_valid(rdv),
      .i_an_speed_100(an_spd), .i_an_full_duplex(an_fd), .o_an_restart(restart),
      .o_full_duplex(fdx), .i_power_down_pin(pd_pin), .o_power_down(pd),
      .i_core_tx_clock(c_tclk), .i_core_rx_valid(c_rxv), .i_core_rxd(c_rxd),
      .i_core_collision(c_col), .o_core_tx_enable(ctxen), .o_core_txd(ctxd),
      .i_link_transmit_enable(l_link_transmit_enable), .i_link_txd(l_txd), .o_link_transmit_clock(tclk),
      .o_link_transmit_clock_oe(tclk_oe), .o_link_receive_valid(rxv),
      .o_link_receive_valid_oe(rxv_oe), .o_link_rxd(rxd), .o_link_rxd_oe(rxd_oe),
      .o_link_collision(col));
   pbc_mgmt_model mgmt (.i_clock(clk), .i_rdata(rdata), .i_rdata_valid(rdv),
      .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
   // -----------------------------
   // Helpers
   // -----------------------------
   task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rchk(input logic [15:0] e);
      mgmt.rd(d);
      check("register", e, d);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   function automatic logic [15:0] oes();
      return {12'h0, tclk_oe, rxv_oe, rxd_oe, ctxen};
   endfunction
   function automatic logic [15:0] lnk();
      return {11'h0, tclk, rxd, ctxd};
   endfunction
   task automatic complete_run();
      $display("Checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // -----------------------------
   // Scenarios
   // -----------------------------
   task automatic t_autoneg();
      @(posedge clk) an_fd <= 1'b0;
      rchk(16'h3000);
      check("duplex", 16'h0, {15'h0, fdx});
      @(posedge clk) an_spd <= 1'b0;
      rchk(16'h1000);
      @(posedge clk) an_spd <= 1'b1;
      mgmt.wr(16'h2100);
      rchk(16'h2100);
      check("duplex", 16'h1, {15'h0, fdx});
      mgmt.wr(16'h2000);
      cyc(2);
      check("duplex", 16'h0, {15'h0, fdx});
      @(posedge clk) an_fd <= 1'b1;
      mgmt.wr(16'h3100);
   endtask
   task automatic t_restart();
      int p;
      p = pulses;
      mgmt.wr(16'h3300);
      rchk(16'h3100);
      check("restarts", 16'h1, 16'(pulses - p));
      p = pulses;
      mgmt.wr(16'h3300, 16'h3100, 1'b1);
      cyc(4);
      check("restarts", 16'h1, 16'(pulses - p));
   endtask
   task automatic t_isolate();
      @(posedge clk) l_link_transmit_enable <= 1'b1;
      cyc(2);
      check("link oe", 16'hF, oes());
      check("link data", 16'h19, lnk());
      @(posedge clk) c_tclk <= 1'b0;
      cyc(2);
      check("link data", 16'h09, lnk());
      @(posedge clk) c_tclk <= 1'b1;
      mgmt.wr(16'h3500);
      cyc(2);
      check("link oe", 16'h0, oes());
      check("link data", 16'h0, lnk());
      rchk(16'h3500);
      mgmt.wr(16'h3900);
      cyc(2);
      check("power down", 16'h1, {15'h0, pd});
      check("link oe", 16'h0, oes());
      rchk(16'h3900);
      mgmt.wr(16'h3100);
      @(posedge clk) pd_pin <= 1'b1;
      c_col <= 1'b1;
      cyc(2);
      check("link oe", 16'h0, oes());
      check("power down", 16'h1, {15'h0, pd});
      check("collision", 16'h0, {15'h0, col});
      @(posedge clk) pd_pin <= 1'b0;
      l_link_transmit_enable <= 1'b0;
      cyc(2);
      check("collision", 16'h1, {15'h0, col});
      @(posedge clk) c_col <= 1'b0;
   endtask
   task automatic t_collision();
      mgmt.wr(16'h3180);
      @(posedge clk) l_link_transmit_enable <= 1'b1;
      cyc(2);
      check("collision", 16'h1, {15'h0, col});
      @(posedge clk) l_link_transmit_enable <= 1'b0;
      cyc(2);
      check("collision", 16'h0, {15'h0, col});
   endtask
   task automatic t_loopback();
      @(posedge clk) c_rxv <= 1'b0;
      l_link_transmit_enable <= 1'b1;
      mgmt.wr(16'h7100);
      cyc(DEAD / 2);
      check("receive valid", 16'h0, {15'h0, rxv});
      cyc(DEAD + 2);
      check("receive valid", 16'h1, {15'h0, rxv});
      check("loopback data", 16'h1, {14'h0, rxd});
   endtask
   task automatic t_softreset();
      mgmt.wr(16'h8000);
      rchk(16'hB100);
      cyc(20);
      rchk(16'h3100);
   endtask
   // -----------------------------
   // Sequence
   // -----------------------------
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rchk(16'h3100);
      t_autoneg();
      t_restart();
      t_isolate();
      t_collision();
      t_loopback();
      t_softreset();
      complete_run();
   end
   initial begin
      #200000;
      num_errors++;
      complete_run();
   end
endmodule // testbench
`default_nettype wire
